// File: rtl/rrc_pkg.sv
// rrc_pkg: encodings, field positions and reset values for the rotate-through-carry execution block
// assumes a 12-bit instruction word and an 8-bit data path
package rrc_pkg;
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 6;
    localparam logic [5:0] OPC_ROT = 6'h0C;
    localparam int DEST_BIT = 5;
    localparam int ADDR_HI = 4;
    localparam int ADDR_LO = 0;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic CARRY_RST = 1'b0;
    localparam logic ZERO_RST = 1'b0;
    localparam logic DC_RST = 1'b0;
    localparam logic [4:0] ADDR_RST = 5'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
endpackage : rrc_pkg

// File: rtl/rrc_rotator.sv
// rrc_rotator: combinational one-bit right rotate through a carry bit
// assumes the caller registers both outputs in the same cycle
`timescale 1ns/1ns
module rrc_rotator #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] din,
    input wire logic cin,
    output logic [WIDTH-1:0] dout,
    output logic cout
);
    if (WIDTH < 2) begin : g_width_check
        $error("rrc_rotator: WIDTH must be at least 2");
    end

    always_comb begin
        dout = {cin, din[WIDTH-1:1]}; // RQ3
        cout = din[0]; // RQ3
    end
endmodule : rrc_rotator

// File: rtl/rrc_exec.sv
// rrc_exec: executes the rotate-right-through-carry operation for an 8-bit core
// assumes the decoder presents one instruction per enabled cycle with the addressed register's value
// Behaviour
// RQ1: recognise the operation when instruction bits 11..6 equal 001100
// RQ2: five low instruction bits address data register 0 to 31
// RQ3: rotate right one bit; old carry enters msb, lsb goes to carry
// RQ4: destination bit 0 writes result to accumulator, register untouched
// RQ5: destination bit 1 writes result back into the addressed register
// RQ6: only carry changes; zero and digit-carry flags keep their values
// RQ7: one word, one cycle; carry and destination update together at cycle end
`timescale 1ns/1ns
module rrc_exec #(
    parameter int DATA_W = rrc_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic insn_valid,
    input wire logic [rrc_pkg::INSN_W-1:0] insn,
    input wire logic [DATA_W-1:0] reg_rdata,
    output logic [rrc_pkg::ADDR_W-1:0] reg_waddr_q,
    output logic [DATA_W-1:0] reg_wdata_q,
    output logic reg_we_q,
    output logic [DATA_W-1:0] w_q,
    output logic carry_q,
    output logic zero_q,
    output logic dc_q,
    output logic done_q
);
    if (DATA_W != rrc_pkg::DATA_W) begin : g_width_check
        $error("rrc_exec: only the documented data width is supported");
    end

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic hit;
    logic dest_reg;
    logic [rrc_pkg::ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rot;
    logic rot_c;

    always_comb begin
        hit = insn_valid && (insn[rrc_pkg::OPC_HI:rrc_pkg::OPC_LO] == rrc_pkg::OPC_ROT); // RQ1
        dest_reg = insn[rrc_pkg::DEST_BIT]; // RQ4 RQ5
        addr = insn[rrc_pkg::ADDR_HI:rrc_pkg::ADDR_LO]; // RQ2
    end

    // the rotator is pure logic so the whole operation fits one cycle
    rrc_rotator #(.WIDTH(DATA_W)) u_rot (
        .din(reg_rdata),
        .cin(carry_q),
        .dout(rot),
        .cout(rot_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // carry and accumulator
    always_ff @(posedge clk) begin
        if (!resetn) begin
            carry_q <= rrc_pkg::CARRY_RST;
        end else if (ce && hit) begin
            carry_q <= rot_c; // RQ3 RQ7
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            w_q <= rrc_pkg::W_RST;
        end else if (ce && hit && !dest_reg) begin
            w_q <= rot; // RQ4
        end
    end

    // zero and digit-carry only loaded by reset here; held as owned state for the core
    always_ff @(posedge clk) begin
        if (!resetn) begin
            zero_q <= rrc_pkg::ZERO_RST;
            dc_q <= rrc_pkg::DC_RST;
        end else begin
            zero_q <= zero_q; // RQ6
            dc_q <= dc_q; // RQ6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register write-back
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_we_q <= 1'b0;
            reg_waddr_q <= rrc_pkg::ADDR_RST;
            reg_wdata_q <= rrc_pkg::DATA_RST;
        end else if (ce) begin
            reg_we_q <= hit && dest_reg; // RQ5 RQ4
            if (hit && dest_reg) begin
                reg_waddr_q <= addr; // RQ5
                reg_wdata_q <= rot; // RQ5
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= hit; // RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_carry_from_lsb;
        @(posedge clk) disable iff (!resetn)
        (ce && hit) |=> (carry_q == $past(reg_rdata[0]));
    endproperty
    a_carry_from_lsb: assert property (p_carry_from_lsb) else $error("carry not taken from lsb"); // RQ3

    property p_acc_result;
        @(posedge clk) disable iff (!resetn)
        (ce && hit && !dest_reg) |=> (w_q == {$past(carry_q), $past(reg_rdata[DATA_W-1:1])});
    endproperty
    a_acc_result: assert property (p_acc_result) else $error("accumulator result wrong"); // RQ4

    property p_acc_no_reg_write;
        @(posedge clk) disable iff (!resetn)
        (ce && hit && !dest_reg) |=> !reg_we_q;
    endproperty
    a_acc_no_reg_write: assert property (p_acc_no_reg_write) else $error("register written for W dest"); // RQ4

    property p_reg_result;
        @(posedge clk) disable iff (!resetn)
        (ce && hit && dest_reg) |=> (reg_we_q && reg_wdata_q == {$past(carry_q), $past(reg_rdata[DATA_W-1:1])}
            && reg_waddr_q == $past(insn[rrc_pkg::ADDR_HI:rrc_pkg::ADDR_LO]));
    endproperty
    a_reg_result: assert property (p_reg_result) else $error("register write-back wrong"); // RQ5 RQ2

    property p_reg_keeps_w;
        @(posedge clk) disable iff (!resetn)
        (ce && hit && dest_reg) |=> $stable(w_q);
    endproperty
    a_reg_keeps_w: assert property (p_reg_keeps_w) else $error("accumulator changed for f dest"); // RQ5

    property p_flags_stable;
        @(posedge clk) disable iff (!resetn)
        (ce && hit) |=> ($stable(zero_q) && $stable(dc_q));
    endproperty
    a_flags_stable: assert property (p_flags_stable) else $error("zero or digit carry changed"); // RQ6

    property p_no_op_no_effect;
        @(posedge clk) disable iff (!resetn)
        (ce && !hit) |=> (!reg_we_q && !done_q && $stable(carry_q) && $stable(w_q));
    endproperty
    a_no_op_no_effect: assert property (p_no_op_no_effect) else $error("action without matching opcode"); // RQ1

    // done stands through a frozen cycle, so only an enabled follow-up may clear it
    property p_single_cycle;
        @(posedge clk) disable iff (!resetn)
        (ce && hit) |=> done_q ##1 (done_q == (!$past(ce) || $past(hit)));
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("done not single cycle"); // RQ7

    property p_freeze;
        @(posedge clk) disable iff (!resetn)
        !ce |=> ($stable(carry_q) && $stable(w_q) && $stable(reg_we_q) && $stable(done_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // RQ7

    property p_freeze_wb;
        @(posedge clk) disable iff (!resetn)
        !ce |=> ($stable(reg_waddr_q) && $stable(reg_wdata_q) && $stable(zero_q) && $stable(dc_q));
    endproperty
    a_freeze_wb: assert property (p_freeze_wb) else $error("write-back or flags moved while disabled"); // RQ6

    property p_reset_state;
        @(posedge clk)
        !resetn |=> (w_q == rrc_pkg::W_RST && carry_q == rrc_pkg::CARRY_RST && zero_q == rrc_pkg::ZERO_RST
            && dc_q == rrc_pkg::DC_RST && !reg_we_q && !done_q);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not at reset value"); // RQ6

    property p_decode_exact;
        @(posedge clk) disable iff (!resetn)
        (ce && insn_valid && insn[rrc_pkg::OPC_HI:rrc_pkg::OPC_LO] == rrc_pkg::OPC_ROT) |=> done_q;
    endproperty
    a_decode_exact: assert property (p_decode_exact) else $error("matching opcode not executed"); // RQ1

    property p_dest_select;
        @(posedge clk) disable iff (!resetn)
        (ce && hit) |=> (reg_we_q == $past(insn[rrc_pkg::DEST_BIT]));
    endproperty
    a_dest_select: assert property (p_dest_select) else $error("destination select not followed"); // RQ4

    property p_we_with_done;
        @(posedge clk) disable iff (!resetn)
        reg_we_q |-> done_q;
    endproperty
    a_we_with_done: assert property (p_we_with_done) else $error("write strobe without completion"); // RQ5

    property p_wb_hold;
        @(posedge clk) disable iff (!resetn)
        (ce && !(hit && dest_reg)) |=> ($stable(reg_waddr_q) && $stable(reg_wdata_q));
    endproperty
    a_wb_hold: assert property (p_wb_hold) else $error("write-back fields moved without a write"); // RQ5

    // the msb is checked on whichever destination took the result
    property p_msb_from_carry;
        @(posedge clk) disable iff (!resetn)
        (ce && hit) |=> ((reg_we_q ? reg_wdata_q[DATA_W-1] : w_q[DATA_W-1]) == $past(carry_q));
    endproperty
    a_msb_from_carry: assert property (p_msb_from_carry) else $error("old carry not in msb"); // RQ3

    // a short reset may also pull carry back to its reset value
    property p_carry_only_by_op;
        @(posedge clk) disable iff (!resetn)
        $changed(carry_q) |-> ($past(ce && hit) || !$past(resetn));
    endproperty
    a_carry_only_by_op: assert property (p_carry_only_by_op) else $error("carry moved without an operation"); // RQ6

    property p_w_only_by_acc;
        @(posedge clk) disable iff (!resetn)
        $changed(w_q) |-> ($past(ce && hit && !dest_reg) || !$past(resetn));
    endproperty
    a_w_only_by_acc: assert property (p_w_only_by_acc) else $error("accumulator moved without a write"); // RQ4

    c_acc: cover property (@(posedge clk) disable iff (!resetn) ce && hit && !dest_reg);
    c_reg: cover property (@(posedge clk) disable iff (!resetn) ce && hit && dest_reg);
    c_back: cover property (@(posedge clk) disable iff (!resetn) (ce && hit) ##1 (ce && hit));
    c_carry_in: cover property (@(posedge clk) disable iff (!resetn) ce && hit && carry_q && reg_rdata[0]);
endmodule : rrc_exec

// File: dv/rrc_regfile_model.sv
// rrc_regfile_model: behavioural 32-entry data register file beside the execution block
// assumes writes land on a rising edge while the write strobe is high
`timescale 1ns/1ns
module rrc_regfile_model #(
    parameter logic [7:0] SEED = 8'hE6,
    parameter logic [7:0] STEP = 8'h11
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [rrc_pkg::ADDR_W-1:0] raddr,
    input wire logic [rrc_pkg::ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic we,
    output logic [7:0] rdata
);
    logic [7:0] mem [32];
    // forward a pending write, else back-to-back ops on one register read stale data
    assign rdata = (we && waddr == raddr) ? wdata : mem[raddr];
    // seeded during reset so the bench knows every start value and only this process writes mem
    always @(posedge clk) begin
        if (!resetn) begin
            for (int k = 0; k < 32; k++) begin
                mem[k] <= SEED + STEP * k[7:0];
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule : rrc_regfile_model

// File: dv/rrc_exec_tb.sv
// rrc_exec_tb: self-checking bench for the rotate-through-carry execution block
// assumes the register file model forwards pending writes
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module rrc_exec_tb;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, insn_valid = 1'b0;
    logic [11:0] insn = 12'h000;
    logic [7:0] rdata, wdata, w, sh_w, ex_d, r;
    logic [7:0] sh_m [32];
    logic [4:0] waddr, ex_a;
    logic we, carry, zero, dc, done, sh_c, ex_we, ex_done;
    int error_cnt = 0, n_compared = 0;
    localparam logic [7:0] RF_SEED = 8'hE6;
    localparam logic [7:0] RF_STEP = 8'h11;
    always #25 clk = ~clk;
    rrc_exec DUT (.clk(clk), .resetn(resetn), .ce(ce), .insn_valid(insn_valid), .insn(insn), .reg_rdata(rdata),
        .reg_waddr_q(waddr), .reg_wdata_q(wdata), .reg_we_q(we), .w_q(w), .carry_q(carry), .zero_q(zero),
        .dc_q(dc), .done_q(done));
    rrc_regfile_model #(.SEED(RF_SEED), .STEP(RF_STEP)) RF (.clk(clk), .resetn(resetn), .raddr(insn[4:0]),
        .waddr(waddr), .wdata(wdata), .we(we), .rdata(rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // shadow state is updated at issue; outputs are judged one edge later
    task automatic run_op(input logic c, input logic v, input logic [11:0] i);
        ce = c;
        insn_valid = v;
        insn = i;
        if (c) begin
            ex_we = 1'b0;
            ex_done = 1'b0;
        end
        if (c && v && i[11:6] == rrc_pkg::OPC_ROT) begin
            r = {sh_c, sh_m[i[4:0]][7:1]};
            sh_c = sh_m[i[4:0]][0];
            ex_done = 1'b1;
            ex_we = i[5];
            if (i[5]) begin
                sh_m[i[4:0]] = r;
                ex_a = i[4:0];
                ex_d = r;
            end else begin
                sh_w = r;
            end
        end
        @(posedge clk);
        #2;
        `CHK(done, ex_done)
        `CHK(we, ex_we)
        `CHK(waddr, ex_a)
        `CHK(wdata, ex_d)
        `CHK(w, sh_w)
        `CHK(carry, sh_c)
        `CHK({zero, dc}, 2'h0)
        `CHK(rdata, sh_m[i[4:0]])
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_dest1();
        run_op(1'b1, 1'b1, 12'h32A);
        run_op(1'b1, 1'b1, 12'h32A);
        run_op(1'b1, 1'b1, 12'h32A);
    endtask : t_dest1
    task automatic t_dest0();
        run_op(1'b1, 1'b1, 12'h300);
        run_op(1'b1, 1'b1, 12'h31F);
        run_op(1'b1, 1'b1, 12'h300);
    endtask : t_dest0
    task automatic t_refused();
        run_op(1'b1, 1'b1, 12'h36A);
        run_op(1'b1, 1'b1, 12'h10A);
        run_op(1'b1, 1'b1, 12'hB0A);
        run_op(1'b1, 1'b0, 12'h32A);
    endtask : t_refused
    task automatic t_freeze();
        run_op(1'b1, 1'b1, 12'h335);
        run_op(1'b0, 1'b1, 12'h315);
        run_op(1'b1, 1'b1, 12'h315);
    endtask : t_freeze
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sh_w, sh_c, ex_a, ex_d, ex_we, ex_done} = '0;
        for (int k = 0; k < 32; k++) begin
            sh_m[k] = RF_SEED + RF_STEP * k[7:0];
        end
        repeat (3) @(posedge clk);
        #2;
        resetn = 1'b1;
        run_op(1'b1, 1'b0, 12'h000);
        t_dest1();
        t_dest0();
        t_refused();
        t_freeze();
        tally_and_finish();
    end
endmodule : rrc_exec_tb
